// >>> clk_tune_pkg.sv
// Functional notes
// - New tuning value drifts in gradually, no flag
// - Source bit picks low-frequency oscillator
// - Four-times multiplier, 32 MHz at most
// - Tuning register bit six enables multiplier
// - Multiplier only with select 00, config 011/010
// - Multiplier only at frequency select 111/110
// - Core keeps clock during two-ms lock
// - Switch to multiplied clock automatically once locked
// - Fast oscillator starts at calibrated 8.0 MHz
// - Low-frequency RC unaffected by tuning writes
package clk_tune_pkg;

  localparam int          CLK_HZ          = 50_000_000;
  localparam int          LOCK_TIME_US    = 2000;
  localparam int          LOCK_CYCLES     = (CLK_HZ / 1_000_000) * LOCK_TIME_US;
  localparam int          DRIFT_STEP_DIV  = 64;

  localparam logic [3:0]  ADDR_TUNE       = 4'h0;
  localparam logic [3:0]  ADDR_CTRL       = 4'h4;
  localparam logic [3:0]  ADDR_STATUS     = 4'h8;

  localparam int          TUNE_SRC_BIT    = 7;
  localparam int          TUNE_PLL_ENABLE_BIT_BIT  = 6;
  localparam int          TUNE_TRIM_LSB   = 0;
  localparam int          TUNE_TRIM_W     = 6;
  localparam logic [7:0]  TUNE_RESET      = 8'h00;

  localparam int          CTRL_SCS_LSB    = 0;
  localparam int          CTRL_IRCF_LSB   = 4;
  localparam int          CTRL_CFG_LSB    = 8;
  localparam logic [10:0] CTRL_RESET      = 11'h370;

  localparam logic [1:0]  SCS_PRIMARY     = 2'h0;
  localparam logic [2:0]  CFG_PLL_A       = 3'h3;
  localparam logic [2:0]  CFG_PLL_B       = 3'h2;
  localparam logic [2:0]  IRCF_8MHZ       = 3'h7;
  localparam logic [2:0]  IRCF_4MHZ       = 3'h6;
  localparam logic [2:0]  IRCF_LOWFREQ    = 3'h0;

  localparam int          NOMINAL_KHZ     = 8000;
  localparam int          PLL_FACTOR      = 4;
  localparam int          MAX_CORE_KHZ    = 32000;

  typedef enum {
    SRC_FAST,
    SRC_PLL_WAIT,
    SRC_PLL
  } clk_state_t;

  typedef struct packed {
    logic [2:0] cfg;
    logic [2:0] ircf;
    logic [1:0] scs;
  } clk_ctrl_t;

  typedef struct packed {
    logic       pll_active;
    logic       pll_locking;
    logic       lf_from_rc;
    logic [5:0] trim_now;
  } clk_status_t;

endpackage : clk_tune_pkg

// >>> trim_slew.sv
`timescale 1ns/1ps
`default_nettype none
module trim_slew
  import clk_tune_pkg::*;
#(
  parameter int W   = TUNE_TRIM_W,
  parameter int DIV = DRIFT_STEP_DIV
) (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [W-1:0] target,
  output logic      [W-1:0] current
);

  logic [W-1:0]  cur_reg;
  logic [W-1:0]  cur_next;
  logic [15:0]   div_reg;
  logic [15:0]   div_next;

  // Step one code per interval toward target
  always_comb begin
    cur_next = cur_reg;
    div_next = div_reg + 16'h0001;
    if (div_reg == 16'(DIV - 1)) begin
      div_next = 16'h0000;
      if ($signed(target) > $signed(cur_reg))
        cur_next = cur_reg + W'(1);
      else if ($signed(target) < $signed(cur_reg))
        cur_next = cur_reg - W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cur_reg <= '0;
      div_reg <= 16'h0000;
    end else if (ce) begin
      cur_reg <= cur_next;
      div_reg <= div_next;
    end
  end

  assign current = cur_reg;

endmodule : trim_slew
`default_nettype wire

// >>> osc_tune_pll.sv
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module osc_tune_pll
  import clk_tune_pkg::*;
#(
  parameter int LOCK_COUNT = LOCK_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [5:0]  fast_osc_trim,
  output logic             low_freq_source_select,
  output logic             core_on_pll,
  output logic             core_on_low_freq
);

  logic [7:0]        tune_reg;
  logic [7:0]        tune_next;
  clk_ctrl_t         ctrl_reg;
  clk_ctrl_t         ctrl_next;
  clk_state_t        st_reg;
  clk_state_t        st_next;
  logic [23:0]       lock_reg;
  logic [23:0]       lock_next;
  logic              ack_reg;
  logic              ack_next;
  logic [31:0]       rdat_reg;
  logic [31:0]       rdat_next;
  logic              pll_reg;
  logic              pll_next;
  logic              lf_reg;
  logic              lf_next;
  logic              srcsel_reg;
  logic              srcsel_next;
  logic [5:0]        trim_now;
  logic              pll_allowed;
  logic              wr;
  logic              rd;
  clk_status_t       status;
  logic [15:0]       ctrl_w;

  // Drift toward written trim, no done flag
  trim_slew #(
    .W   (TUNE_TRIM_W),
    .DIV (DRIFT_STEP_DIV)
  ) u_slew (
    .core_clk (core_clk),
    .nrst     (nrst),
    .ce       (ce),
    .target   (tune_reg[TUNE_TRIM_LSB +: TUNE_TRIM_W]),
    .current  (trim_now)
  );

  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg;
  assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg;

  assign pll_allowed = tune_reg[TUNE_PLL_ENABLE_BIT_BIT]
                    && ctrl_reg.scs == SCS_PRIMARY
                    && (ctrl_reg.cfg == CFG_PLL_A || ctrl_reg.cfg == CFG_PLL_B)
                    && (ctrl_reg.ircf == IRCF_8MHZ || ctrl_reg.ircf == IRCF_4MHZ);

  assign status = '{pll_active:  st_reg == SRC_PLL,
                    pll_locking: st_reg == SRC_PLL_WAIT,
                    lf_from_rc:  ~tune_reg[TUNE_SRC_BIT],
                    trim_now:    trim_now};

  assign ctrl_w = {5'h00, ctrl_reg.cfg, 1'b0, ctrl_reg.ircf, 2'h0, ctrl_reg.scs};

  // Register file
  always_comb begin
    tune_next = tune_reg;
    ctrl_next = ctrl_reg;
    ack_next  = wb_cyc_i && wb_stb_i && !ack_reg;
    rdat_next = rdat_reg;
    if (wr && wb_adr_i == ADDR_TUNE && wb_sel_i[0])
      tune_next = wb_dat_i[7:0];
    if (wr && wb_adr_i == ADDR_CTRL) begin
      if (wb_sel_i[0]) begin
        ctrl_next.scs  = wb_dat_i[CTRL_SCS_LSB +: 2];
        ctrl_next.ircf = wb_dat_i[CTRL_IRCF_LSB +: 3];
      end
      if (wb_sel_i[1])
        ctrl_next.cfg = wb_dat_i[CTRL_CFG_LSB +: 3];
    end
    if (rd) begin
      case (wb_adr_i)
        ADDR_TUNE:   rdat_next = {24'h000000, tune_reg};
        ADDR_CTRL:   rdat_next = {16'h0000, ctrl_w};
        ADDR_STATUS: rdat_next = {23'h000000, status};
        default:     rdat_next = 32'h00000000;
      endcase
    end
  end

  // Core clock source sequencing
  always_comb begin
    st_next   = st_reg;
    lock_next = lock_reg;
    case (st_reg)
      SRC_FAST: begin
        lock_next = 24'h000000;
        if (pll_allowed)
          st_next = SRC_PLL_WAIT;
      end
      SRC_PLL_WAIT: begin
        lock_next = lock_reg + 24'h000001;
        if (!pll_allowed)
          st_next = SRC_FAST;
        else if (lock_reg == 24'(LOCK_COUNT - 1))
          st_next = SRC_PLL;
      end
      SRC_PLL: begin
        if (!pll_allowed)
          st_next = SRC_FAST;
      end
      default: st_next = SRC_FAST;
    endcase
  end

  // Output selects
  always_comb begin
    pll_next    = (st_next == SRC_PLL);
    lf_next     = (ctrl_next.ircf == IRCF_LOWFREQ) && !pll_next;
    srcsel_next = tune_next[TUNE_SRC_BIT];
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tune_reg   <= TUNE_RESET;
      ctrl_reg   <= '{cfg:  CTRL_RESET[CTRL_CFG_LSB +: 3],
                      ircf: CTRL_RESET[CTRL_IRCF_LSB +: 3],
                      scs:  CTRL_RESET[CTRL_SCS_LSB +: 2]};
      st_reg     <= SRC_FAST;
      lock_reg   <= 24'h000000;
      ack_reg    <= 1'b0;
      rdat_reg   <= 32'h00000000;
      pll_reg    <= 1'b0;
      lf_reg     <= 1'b0;
      srcsel_reg <= 1'b0;
    end else if (ce) begin
      tune_reg   <= tune_next;
      ctrl_reg   <= ctrl_next;
      st_reg     <= st_next;
      lock_reg   <= lock_next;
      ack_reg    <= ack_next;
      rdat_reg   <= rdat_next;
      pll_reg    <= pll_next;
      lf_reg     <= lf_next;
      srcsel_reg <= srcsel_next;
    end
  end

  assign wb_ack_o               = ack_reg;
  assign wb_dat_o               = rdat_reg;
  assign fast_osc_trim          = trim_now;
  assign core_on_pll            = pll_reg;
  assign core_on_low_freq       = lf_reg;
  assign low_freq_source_select = srcsel_reg;

endmodule : osc_tune_pll
`default_nettype wire

// >>> osc_tune_pll_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module osc_tune_pll_monitor
  import clk_tune_pkg::*;
#(
  parameter int LOCK_COUNT = LOCK_CYCLES
) (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        ce,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [5:0]  fast_osc_trim,
  input wire logic        low_freq_source_select,
  input wire logic        core_on_pll,
  input wire logic        core_on_low_freq
);
  int off_reg;
  int off_next;
  // Cycles spent off the multiplied clock
  always_comb begin
    off_next = (core_on_pll || off_reg >= LOCK_COUNT) ? (core_on_pll ? 0 : off_reg) : off_reg + 1;
  end
  always_ff @(posedge core_clk) begin
    off_reg <= nrst ? off_next : 0;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence req_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  endsequence
  sequence ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence wr_seen;
    $past(wb_we_i && wb_stb_i);
  endsequence
  chk_ack_timing: assert property (req_taken |=> ack_once)
    else $error("ack not a single pulse after request");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_pll_lock: assert property ($rose(core_on_pll) |-> off_reg >= LOCK_COUNT)
    else $error("multiplied clock before lock time");
  chk_pll_exclusive: assert property (core_on_pll |-> !core_on_low_freq)
    else $error("low frequency and multiplier together");
  chk_pll_drop: assert property ($fell(core_on_pll) |-> wr_seen)
    else $error("multiplier dropped without write");
  chk_src_write: assert property ($changed(low_freq_source_select) |-> wr_seen)
    else $error("source select moved without write");
  chk_lf_write: assert property ($changed(core_on_low_freq) |-> wr_seen)
    else $error("low frequency flag moved without write");
  chk_trim_step: assert property ($changed(fast_osc_trim)
    |-> 6'(fast_osc_trim - $past(fast_osc_trim)) inside {6'h01, 6'h3f})
    else $error("trim jumped");
  chk_trim_pace: assert property ($changed(fast_osc_trim) |=> $stable(fast_osc_trim)[*8])
    else $error("trim steps too fast");
endmodule : osc_tune_pll_monitor
bind osc_tune_pll osc_tune_pll_monitor #(.LOCK_COUNT(LOCK_COUNT)) mon (.core_clk, .nrst, .ce,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .fast_osc_trim, .low_freq_source_select, .core_on_pll, .core_on_low_freq);
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import clk_tune_pkg::*;
;
  localparam int LOCK = 20;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        ce = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic [31:0] q;
  logic        wb_ack_o;
  logic        low_freq_source_select;
  logic        core_on_pll;
  logic        core_on_low_freq;
  logic [5:0]  fast_osc_trim;
  clk_ctrl_t   c;
  int          num_errors = 0;
  int          samples_checked = 0;
  always #10 core_clk = ~core_clk;
  osc_tune_pll #(.LOCK_COUNT(LOCK)) uut (.core_clk, .nrst, .ce, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .fast_osc_trim,
    .low_freq_source_select, .core_on_pll, .core_on_low_freq);
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1 && n++ < 100);
    if (n > 100) num_errors++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : xfer
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic chk_bit(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask : chk_bit
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
  endtask : hold
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  initial begin
    hold(4);
    nrst <= 1'b1;
    rd(ADDR_TUNE, 32'h0);
    rd(ADDR_CTRL, 32'h370);
    rd(ADDR_STATUS, 32'h40);
    rd(4'hc, 32'h0);
    xfer(1'b1, ADDR_TUNE, 32'h85);
    hold(2);
    chk_bit(low_freq_source_select, 1'b1);
    chk_bit(fast_osc_trim <= 6'h01, 1'b1);
    hold(6 * DRIFT_STEP_DIV);
    chk({26'h0, fast_osc_trim}, 32'h5);
    rd(ADDR_STATUS, 32'h5);
    $display("tune test done");
    xfer(1'b1, ADDR_CTRL, 32'h300);
    xfer(1'b1, ADDR_TUNE, 32'h3f);
    hold(2);
    chk_bit(core_on_low_freq, 1'b1);
    chk_bit(low_freq_source_select, 1'b0);
    // Enable low freezes the drifting trim
    ce <= 1'b0;
    hold(1);
    q = {26'h0, fast_osc_trim};
    hold(3 * DRIFT_STEP_DIV);
    chk({26'h0, fast_osc_trim}, q);
    ce <= 1'b1;
    $display("low frequency test done");
    // Software drift correction steps
    rd(ADDR_TUNE, 32'h3f);
    xfer(1'b1, ADDR_TUNE, q - 32'h1);
    rd(ADDR_TUNE, 32'h3e);
    xfer(1'b1, ADDR_TUNE, q + 32'h1);
    rd(ADDR_TUNE, 32'h3f);
    $display("correction test done");
    for (int i = 0; i < 24; i++) begin
      c = i < 8 ? {3'(i), IRCF_8MHZ, SCS_PRIMARY} : i < 16 ? {CFG_PLL_B, 3'(i), SCS_PRIMARY}
        : {CFG_PLL_A, IRCF_4MHZ, 2'(i)};
      xfer(1'b1, ADDR_TUNE, 32'h0);
      hold(2);
      chk_bit(core_on_pll, 1'b0);
      xfer(1'b1, ADDR_CTRL, {21'h0, c.cfg, 1'b0, c.ircf, 2'h0, c.scs});
      xfer(1'b1, ADDR_TUNE, 32'h40);
      hold(LOCK - 1);
      chk_bit(core_on_pll, 1'b0);
      hold(2);
      chk_bit(core_on_pll, c.scs == 2'h0 && c.cfg[2:1] == 2'h1 && c.ircf[2:1] == 2'h3);
    end
    $display("multiplier test done");
    finish_test();
  end
  initial begin
    #200_000;
    num_errors++;
    finish_test();
  end
endmodule : testbench
`default_nettype wire
